/* design/irq_wake_pkg.sv */
// package: register map, field layout, carriers and state types of the flag block
`default_nettype none
package irq_wake_pkg;

  localparam int REG_AW = 6;
  localparam int WAKE_PINS = 8;

  // byte offsets of the word registers on the bus
  localparam logic [REG_AW-1:0] OFS_INT_FLAGS  = 6'h00;
  localparam logic [REG_AW-1:0] OFS_WAKE_FLAGS = 6'h04;
  localparam logic [REG_AW-1:0] OFS_WAKE_EDGE  = 6'h08;
  localparam logic [REG_AW-1:0] OFS_INT_EN     = 6'h0C;
  localparam logic [REG_AW-1:0] OFS_WAKE_EN    = 6'h10;
  localparam logic [REG_AW-1:0] OFS_WAKE_MODE  = 6'h14;
  localparam logic [REG_AW-1:0] OFS_IRQ_STAT   = 6'h18;
  localparam logic [REG_AW-1:0] OFS_IRQ_MASK   = 6'h1C;
  localparam logic [REG_AW-1:0] OFS_CPU_STAT   = 6'h20;

  // internal request flag positions
  localparam int BIT_DT  = 7;
  localparam int BIT_AD  = 6;
  localparam int BIT_TFH = 3;
  localparam int BIT_TFL = 2;
  localparam int BIT_EC  = 0;
  localparam logic [7:0] INT_FLAG_MASK = 8'hCD;

  // summary interrupt status positions
  localparam int IRQ_W    = 3;
  localparam int IRQ_INT  = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_BOOT = 2;

  // cpu status register layout
  localparam int CPU_MASK_BIT = 16;
  localparam int CPU_RUN_BIT  = 17;

  localparam logic [7:0]       FLAGS_RST  = 8'h00;
  localparam logic [7:0]       CTRL_RST   = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST    = 3'h0;
  localparam logic [15:0]      VEC_ADDR_HI = 16'h0000;
  localparam logic [15:0]      VEC_ADDR_LO = 16'h0001;
  localparam logic [15:0]      PC_RST     = 16'h0000;

  typedef enum logic [2:0] {
    BOOT_MASK,
    BOOT_FETCH_HI,
    BOOT_FETCH_LO,
    BOOT_RUN
  } boot_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [REG_AW-1:0] address;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } av_req_t;

  typedef struct packed {
    logic       sleep_direct;
    logic       direct_transition_on;
    logic       adc_done;
    logic       conversion_start_flag;
    logic       timer_16bit_mode;
    logic [7:0] timer_count_high;
    logic [7:0] timer_count_low;
    logic [7:0] timer_compare_high;
    logic [7:0] timer_compare_low;
    logic       counter_16bit_mode;
    logic       event_count_high_ovf;
    logic       event_count_low_ovf;
  } periph_evt_t;

  typedef struct packed {
    logic [7:0]       int_flags;
    logic [7:0]       wake_flags;
    logic [7:0]       wake_edge;
    logic [7:0]       int_en;
    logic [7:0]       wake_en;
    logic [7:0]       wake_mode;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic             ack;
    logic [31:0]      readdata;
    boot_t            boot;
    logic             ccr_mask;
    logic [15:0]      pc;
    logic             pc_load;
    logic             vec_rd;
    logic [15:0]      vec_addr;
    logic             prev_tfh;
    logic             prev_tfl;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_STATE_RST = '{
    int_flags:  FLAGS_RST,
    wake_flags: FLAGS_RST,
    wake_edge:  CTRL_RST,
    int_en:     CTRL_RST,
    wake_en:    CTRL_RST,
    wake_mode:  CTRL_RST,
    irq_stat:   IRQ_RST,
    irq_mask:   IRQ_RST,
    ack:        1'b0,
    readdata:   32'h0000_0000,
    boot:       BOOT_MASK,
    ccr_mask:   1'b0,
    pc:         PC_RST,
    pc_load:    1'b0,
    vec_rd:     1'b0,
    vec_addr:   VEC_ADDR_HI,
    prev_tfh:   1'b0,
    prev_tfl:   1'b0
  };

endpackage
`default_nettype wire

/* design/wake_edge_detect.sv */
// module: wakeup pin synchroniser and per-pin selected-edge pulse
`default_nettype none
module wake_edge_detect
  import irq_wake_pkg::*;
#(
  parameter int N = WAKE_PINS
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [N-1:0] pin_i,
  input  wire logic [N-1:0] polarity_i,
  input  wire logic [N-1:0] mode_i,
  output logic      [N-1:0] edge_o
);

  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] prev;
    logic [N-1:0] pulse;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s       = s;
    // sync1 feeds only sync2; all decisions look at later stages
    next_s.sync1 = pin_i;
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;
    for (int i = 0; i < N; i++) begin
      // 1 picks rising, 0 picks falling
      if (polarity_i[i]) begin
        next_s.pulse[i] = mode_i[i] & s.sync2[i] & ~s.prev[i];
      end else begin
        next_s.pulse[i] = mode_i[i] & ~s.sync2[i] & s.prev[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // pins idle high after reset would read as a rising edge; prev starts low
  // and pulses are gated by mode_i, which is clear after reset
  assign edge_o = s.pulse;

endmodule
`default_nettype wire

/* design/irq_flags_wakeup_reset.sv */
// module: interrupt request flags, wakeup flags and reset exception sequencing
//
// Contract
// - Set the direct-transition flag (bit 7) when a sleep makes a direct transition with direct_transition_on set.
// - Set the A/D flag (bit 6) when a conversion finishes with the conversion-start flag cleared.
// - Set the timer high flag (bit 3) on a high-byte match in 8-bit mode or a full 16-bit match in 16-bit mode.
// - Set the timer low flag (bit 2) on a low-byte match, only in 8-bit mode.
// - Set the event counter flag (bit 0) on high overflow, or in 8-bit mode on high or low overflow.
// - Flags stay set after acceptance and clear only when software writes 0 to a bit reading 1.
// - Writing 1 to a flag bit does nothing; only 0 acts, and only to clear.
// - Set wakeup flag n when pin n is configured for wakeup and its selected edge is seen.
// - Each edge-select bit picks falling edges at 0 and rising edges at 1.
// - While the reset pin is low, all processing halts and all state is initialised.
// - On reset release, reset handling starts by setting the interrupt mask bit to 1.
// - Then the reset vector is read from addresses 0000 and 0001, loaded into the PC and run.
// - A request goes to arbitration only while its flag and its enable bit are both 1.
`default_nettype none
module irq_flags_wakeup_reset
  import irq_wake_pkg::*;
#(
  parameter int N_WAKE = WAKE_PINS
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // avalon-mm slave
  input  wire av_req_t           av_i,
  output logic                   av_waitrequest_o,
  output logic [31:0]            av_readdata_o,
  // peripheral events
  input  wire periph_evt_t       evt_i,
  // wakeup pins
  input  wire logic [N_WAKE-1:0] wakeup_pin_i,
  // requests to arbitration
  output logic [7:0]             int_request_o,
  output logic [N_WAKE-1:0]      wake_request_o,
  // reset vector fetch
  output logic                   vec_rd_o,
  output logic [15:0]            vec_addr_o,
  input  wire logic              vec_ack_i,
  input  wire logic [7:0]        vec_data_i,
  // cpu side
  output logic                   ccr_mask_o,
  output logic [15:0]            pc_o,
  output logic                   pc_load_o,
  output logic                   cpu_run_o,
  // summary interrupt
  output logic                   irq_o
);

  ctrl_state_t       s;
  ctrl_state_t       next_s;
  logic [7:0]        int_set;
  logic [7:0]        wake_next;
  logic [N_WAKE-1:0] wake_set;
  logic [IRQ_W-1:0]  irq_set;
  logic              tfh_match;
  logic              tfl_match;
  logic              bus_req;
  logic              wr_go;
  logic [7:0]        wd;
  logic              boot_done;

  // hardware set wins over a clear landing in the same cycle
  function automatic logic [7:0] flag_update(
    input logic [7:0] cur,
    input logic [7:0] set,
    input logic       hit,
    input logic [7:0] wdata
  );
    logic [7:0] keep;
    keep = hit ? wdata : 8'hFF;
    return (cur & keep) | set;
  endfunction

  function automatic logic [31:0] reg_read(
    input ctrl_state_t      st,
    input logic [REG_AW-1:0] addr
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    case (addr)
      OFS_INT_FLAGS:  r[7:0] = st.int_flags;
      OFS_WAKE_FLAGS: r[7:0] = st.wake_flags;
      OFS_WAKE_EDGE:  r[7:0] = st.wake_edge;
      OFS_INT_EN:     r[7:0] = st.int_en;
      OFS_WAKE_EN:    r[7:0] = st.wake_en;
      OFS_WAKE_MODE:  r[7:0] = st.wake_mode;
      OFS_IRQ_STAT:   r[IRQ_W-1:0] = st.irq_stat;
      OFS_IRQ_MASK:   r[IRQ_W-1:0] = st.irq_mask;
      OFS_CPU_STAT: begin
        r[15:0]         = st.pc;
        r[CPU_MASK_BIT] = st.ccr_mask;
        r[CPU_RUN_BIT]  = (st.boot == BOOT_RUN);
      end
      default:        r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  wake_edge_detect #(
    .N (N_WAKE)
  ) u_wake_edge (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .pin_i      (wakeup_pin_i),
    .polarity_i (s.wake_edge[N_WAKE-1:0]),
    .mode_i     (s.wake_mode[N_WAKE-1:0]),
    .edge_o     (wake_set)
  );

  // match is a level while the counter sits on the compare value;
  // only its first cycle counts so a cleared flag is not re-set at once
  always_comb begin
    if (evt_i.timer_16bit_mode) begin
      tfh_match = ({evt_i.timer_count_high, evt_i.timer_count_low} ==
                   {evt_i.timer_compare_high, evt_i.timer_compare_low});
    end else begin
      tfh_match = (evt_i.timer_count_high == evt_i.timer_compare_high);
    end
    tfl_match = !evt_i.timer_16bit_mode &&
                (evt_i.timer_count_low == evt_i.timer_compare_low);
  end

  always_comb begin
    int_set          = 8'h00;
    int_set[BIT_DT]  = evt_i.sleep_direct && evt_i.direct_transition_on;
    int_set[BIT_AD]  = evt_i.adc_done && !evt_i.conversion_start_flag;
    int_set[BIT_TFH] = tfh_match && !s.prev_tfh;
    int_set[BIT_TFL] = tfl_match && !s.prev_tfl;
    int_set[BIT_EC]  = evt_i.event_count_high_ovf ||
                       (!evt_i.counter_16bit_mode && evt_i.event_count_low_ovf);
  end

  // one wait cycle: request seen, then acknowledged on the next edge
  assign bus_req   = av_i.read || av_i.write;
  assign wr_go     = av_i.write && s.ack && av_i.byteenable[0];
  assign wd        = av_i.writedata[7:0];
  assign boot_done = vec_ack_i && (s.boot == BOOT_FETCH_LO);

  always_comb begin
    irq_set           = '0;
    irq_set[IRQ_INT]  = |int_set;
    irq_set[IRQ_WAKE] = |wake_set;
    irq_set[IRQ_BOOT] = boot_done;
  end

  always_comb begin
    next_s          = s;
    next_s.pc_load  = 1'b0;
    next_s.prev_tfh = tfh_match;
    next_s.prev_tfl = tfl_match;
    next_s.ack      = bus_req && !s.ack;

    if (av_i.read && !s.ack) begin
      next_s.readdata = reg_read(s, av_i.address);
    end

    // reserved bits never set and never store what software writes
    next_s.int_flags = flag_update(s.int_flags, int_set,
                                   wr_go && (av_i.address == OFS_INT_FLAGS),
                                   wd) & INT_FLAG_MASK;
    // flags above the pin count stay at their reset value
    wake_next = flag_update(s.wake_flags, 8'(wake_set),
                            wr_go && (av_i.address == OFS_WAKE_FLAGS), wd);
    next_s.wake_flags[N_WAKE-1:0] = wake_next[N_WAKE-1:0];
    next_s.irq_stat = s.irq_stat | irq_set;

    if (wr_go) begin
      case (av_i.address)
        OFS_WAKE_EDGE: next_s.wake_edge = wd;
        OFS_INT_EN:    next_s.int_en    = wd & INT_FLAG_MASK;
        OFS_WAKE_EN:   next_s.wake_en   = wd;
        OFS_WAKE_MODE: next_s.wake_mode = wd;
        OFS_IRQ_MASK:  next_s.irq_mask  = wd[IRQ_W-1:0];
        OFS_IRQ_STAT:  next_s.irq_stat  = (s.irq_stat & ~wd[IRQ_W-1:0]) | irq_set;
        default:       next_s.irq_mask  = s.irq_mask;
      endcase
    end

    // reset handling: mask first, then the two vector bytes, then run
    case (s.boot)
      BOOT_MASK: begin
        next_s.ccr_mask = 1'b1;
        next_s.vec_rd   = 1'b1;
        next_s.vec_addr = VEC_ADDR_HI;
        next_s.boot     = BOOT_FETCH_HI;
      end
      BOOT_FETCH_HI: begin
        if (vec_ack_i) begin
          next_s.pc[15:8] = vec_data_i;
          next_s.vec_addr = VEC_ADDR_LO;
          next_s.boot     = BOOT_FETCH_LO;
        end
      end
      BOOT_FETCH_LO: begin
        if (vec_ack_i) begin
          next_s.pc[7:0]  = vec_data_i;
          next_s.vec_rd   = 1'b0;
          next_s.pc_load  = 1'b1;
          next_s.boot     = BOOT_RUN;
        end
      end
      BOOT_RUN: begin
        next_s.boot = BOOT_RUN;
      end
      default: begin
        next_s.boot = BOOT_MASK;
      end
    endcase
  end

  // whole state returns to its reset image while the pin is held low
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= CTRL_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign av_waitrequest_o = bus_req && !s.ack;
  assign av_readdata_o    = s.readdata;

  // the summary irq only flags events; it does not gate arbitration
  assign int_request_o  = s.int_flags & s.int_en;
  assign wake_request_o = s.wake_flags[N_WAKE-1:0] & s.wake_en[N_WAKE-1:0];

  assign vec_rd_o   = s.vec_rd;
  assign vec_addr_o = s.vec_addr;
  assign ccr_mask_o = s.ccr_mask;
  assign pc_o       = s.pc;
  assign pc_load_o  = s.pc_load;
  // nothing runs until the vector is in the pc
  assign cpu_run_o  = (s.boot == BOOT_RUN);
  assign irq_o      = |(s.irq_stat & s.irq_mask);

endmodule
`default_nettype wire

/* bench/irq_flags_monitor.sv */
// checker: port-level assertions for the request flag and boot block
`default_nettype none
module irq_flags_monitor
  import irq_wake_pkg::*;
#(
  parameter int N_WAKE = WAKE_PINS
) (
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire av_req_t           av_i,
  input wire logic              av_waitrequest_o,
  input wire logic [31:0]       av_readdata_o,
  input wire periph_evt_t       evt_i,
  input wire logic [N_WAKE-1:0] wakeup_pin_i,
  input wire logic [7:0]        int_request_o,
  input wire logic [N_WAKE-1:0] wake_request_o,
  input wire logic              vec_rd_o,
  input wire logic [15:0]       vec_addr_o,
  input wire logic              vec_ack_i,
  input wire logic [7:0]        vec_data_i,
  input wire logic              ccr_mask_o,
  input wire logic [15:0]       pc_o,
  input wire logic              pc_load_o,
  input wire logic              cpu_run_o,
  input wire logic              irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire periph_evt_t v = evt_i;
  wire logic m_fh = v.timer_16bit_mode ? {v.timer_count_high, v.timer_count_low} ==
    {v.timer_compare_high, v.timer_compare_low} : v.timer_count_high == v.timer_compare_high;
  wire logic m_fl = !v.timer_16bit_mode && v.timer_count_low == v.timer_compare_low;
  logic [7:0] en;
  // shadow of the enables: flags are only visible here through the request outputs
  always_ff @(posedge clk_i) begin
    if (!rstn_i) en <= 8'h00;
    else if (av_i.write && !av_waitrequest_o && av_i.byteenable[0] && av_i.address == OFS_INT_EN)
      en <= av_i.writedata[7:0] & INT_FLAG_MASK;
  end
  sequence s_hi; vec_rd_o && vec_ack_i && vec_addr_o == 16'h0000; endsequence
  sequence s_lo; vec_rd_o && vec_ack_i && vec_addr_o == 16'h0001; endsequence
  property p_boot; $rose(rstn_i) |=> ccr_mask_o && vec_rd_o && vec_addr_o == 16'h0000; endproperty
  property p_halt; disable iff (1'b0) !rstn_i |=> !ccr_mask_o && !cpu_run_o && !vec_rd_o && !irq_o
    && int_request_o == 8'h00; endproperty
  property p_hi; s_hi |=> vec_rd_o && vec_addr_o == 16'h0001 && pc_o[15:8] == $past(vec_data_i); endproperty
  property p_lo; s_lo |=> pc_load_o && cpu_run_o && !vec_rd_o && pc_o[7:0] == $past(vec_data_i)
    ##1 !pc_load_o; endproperty
  property p_keep; |($past(int_request_o) & ~int_request_o) || |($past(wake_request_o) & ~wake_request_o)
    |-> $past(av_i.write); endproperty
  property p_dt; v.sleep_direct && v.direct_transition_on && en[BIT_DT] |=> int_request_o[BIT_DT]; endproperty
  property p_ad; v.adc_done && !v.conversion_start_flag && en[BIT_AD] |=> int_request_o[BIT_AD]; endproperty
  property p_fh; $rose(m_fh) && en[BIT_TFH] |=> int_request_o[BIT_TFH]; endproperty
  property p_fl; $rose(m_fl) && en[BIT_TFL] |=> int_request_o[BIT_TFL]; endproperty
  property p_ec; (v.event_count_high_ovf || !v.counter_16bit_mode && v.event_count_low_ovf) && en[BIT_EC]
    |=> int_request_o[BIT_EC]; endproperty
  property p_gate; (int_request_o & ~en) == 8'h00; endproperty
  a_boot: assert property (p_boot) else $error("no mask and fetch after reset");
  a_halt: assert property (p_halt) else $error("state not cleared in reset");
  a_hi: assert property (p_hi) else $error("high vector byte step wrong");
  a_lo: assert property (p_lo) else $error("low vector byte step wrong");
  a_keep: assert property (p_keep) else $error("request dropped without a write");
  a_dt: assert property (p_dt) else $error("direct transition flag not set");
  a_ad: assert property (p_ad) else $error("conversion flag not set");
  a_fh: assert property (p_fh) else $error("timer high flag not set");
  a_fl: assert property (p_fl) else $error("timer low flag not set");
  a_ec: assert property (p_ec) else $error("event counter flag not set");
  a_gate: assert property (p_gate) else $error("request without enable");
endmodule
bind irq_flags_wakeup_reset irq_flags_monitor #(.N_WAKE(N_WAKE)) irq_flags_monitor_i (.*);
`default_nettype wire

/* bench/boot_rom_model.sv */
// model: vector memory answering the boot fetch after a chosen delay
`default_nettype none
module boot_rom_model #(
  parameter logic [15:0] VEC = 16'h3C5A
) (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [3:0]  delay_i,
  output logic             ack_o,
  output logic [7:0]       data_o
);
  int cnt;
  initial begin
    ack_o = 1'b0;
    data_o = 8'h5A;
    cnt = 0;
  end
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    // an idle bus churns, so stale bytes never look valid
    data_o <= ~data_o;
    if (rd_i && !ack_o) begin
      if (cnt >= 32'(delay_i)) begin
        ack_o <= 1'b1;
        data_o <= (addr_i == 16'h0000) ? VEC[15:8] : VEC[7:0];
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/test_irq_flags_wakeup_reset.sv */
// testbench: flag block over the register bus, peripheral events, wakeup pins and boot fetch
`default_nettype none
module test_irq_flags_wakeup_reset import irq_wake_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] VEC = 16'h3C5A;
  localparam periph_evt_t IDLE = '{timer_compare_high: 8'hFF, timer_compare_low: 8'hFF, default: '0};
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  av_req_t     av = '0;
  periph_evt_t ev = IDLE;
  logic [7:0]  pin = 8'h00;
  logic [3:0]  dly = 4'h0;
  logic [31:0] q, rd, seed = 32'h1;
  logic [15:0] va, pc;
  logic [7:0]  ireq, wreq, vd;
  logic        wr, vrd, vack, condition_code_reg, pld, run, irq;
  int          mismatches = 0;
  int          total_checks = 0;
  irq_flags_wakeup_reset irq_flags_wakeup_reset_i (.clk_i(clk_i), .rstn_i(rstn_i), .av_i(av),
    .av_waitrequest_o(wr), .av_readdata_o(rd), .evt_i(ev), .wakeup_pin_i(pin), .int_request_o(ireq),
    .wake_request_o(wreq), .vec_rd_o(vrd), .vec_addr_o(va), .vec_ack_i(vack), .vec_data_i(vd),
    .ccr_mask_o(condition_code_reg), .pc_o(pc), .pc_load_o(pld), .cpu_run_o(run), .irq_o(irq));
  boot_rom_model #(.VEC(VEC)) boot_rom_model_i (.clk_i(clk_i), .rd_i(vrd), .addr_i(va), .delay_i(dly),
    .ack_o(vack), .data_o(vd));
  initial forever #5 clk_i = ~clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // s: sleep, on, adc, start, t16, hi match, lo match, c16, hi ovf, lo ovf
  function automatic logic [7:0] model(input logic [9:0] s);
    return {s[9] & s[8], s[7] & ~s[6], 2'b00, s[5] ? s[4] & s[3] : s[4], ~s[5] & s[3], 1'b0, s[1] | (~s[2] & s[0])};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    av <= '{read: !w, write: w, address: a, writedata: {24'h0, d}, byteenable: 4'hF};
    do begin
      @(posedge clk_i);
      n++;
    end while (wr !== 1'b0 && n < 50);
    check(n < 50, 1);
    q = rd;
    av <= '0;
    @(negedge clk_i);
  endtask
  task automatic boot(input int cyc, input logic [3:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    rstn_i <= 1'b0;
    dly <= d;
    repeat (cyc) @(negedge clk_i);
    check({condition_code_reg, run, pc, ireq}, 0);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    do begin
      @(negedge clk_i);
      n++;
    end while (run !== 1'b1 && n < 100);
    check({condition_code_reg, pc}, {1'b1, VEC});
    bus(0, OFS_CPU_STAT, 8'h00);
    check(q, {14'h0, 1'b1, 1'b1, VEC});
  endtask
  task automatic fire(input logic [9:0] s);
    logic [7:0] c;
    periph_evt_t e;
    c = 8'(rnd());
    e = IDLE;
    {e.sleep_direct, e.direct_transition_on, e.adc_done, e.conversion_start_flag} = s[9:6];
    {e.timer_16bit_mode, e.counter_16bit_mode, e.event_count_high_ovf, e.event_count_low_ovf} = {s[5], s[2:0]};
    {e.timer_count_high, e.timer_count_low} = {c, c};
    e.timer_compare_high = s[4] ? c : ~c;
    e.timer_compare_low = s[3] ? c : ~c;
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= IDLE;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200us;
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [9:0] s;
    logic [7:0] f, e8, w;
    boot(16, 4'h0);
    for (int a = 0; a < 8; a++) begin
      bus(0, 6'(a * 4), 8'h00);
      check(q, (a == 6) ? 32'h4 : 32'h0);
    end
    bus(1, 6'h3C, 8'hFF);
    bus(0, 6'h3C, 8'h00);
    check(q, 0);
    bus(1, OFS_INT_EN, 8'hCD);
    repeat (32) begin
      s = 10'(rnd());
      bus(1, OFS_INT_FLAGS, 8'h00);
      fire(s);
      bus(0, OFS_INT_FLAGS, 8'h00);
      f = model(s);
      check(q, {24'h0, f});
      check(ireq, f);
    end
    fire(10'h380);
    f = f | 8'hC0;
    bus(1, OFS_INT_FLAGS, 8'hCD);
    bus(0, OFS_INT_FLAGS, 8'h00);
    check(q, {24'h0, f});
    bus(1, OFS_INT_FLAGS, 8'h8D);
    f = f & 8'h8D;
    bus(0, OFS_INT_FLAGS, 8'h00);
    check(q, {24'h0, f});
    bus(1, OFS_INT_EN, 8'h00);
    check(ireq, 0);
    bus(1, OFS_WAKE_EN, 8'hFF);
    bus(1, OFS_WAKE_MODE, 8'h7F);
    e8 = 8'(rnd());
    bus(1, OFS_WAKE_EDGE, e8);
    bus(0, OFS_WAKE_EDGE, 8'h00);
    check(q, {24'h0, e8});
    for (int k = 0; k < 16; k++) begin
      bus(1, OFS_WAKE_FLAGS, 8'h00);
      @(posedge clk_i);
      pin[k/2] <= ~pin[k/2];
      repeat (8) @(posedge clk_i);
      bus(0, OFS_WAKE_FLAGS, 8'h00);
      w = 8'(k < 14 && e8[k/2] == ~k[0]) << k/2;
      check(q, {24'h0, w});
      check(wreq, w);
    end
    bus(1, OFS_IRQ_MASK, 8'h02);
    check(irq, 1);
    bus(1, OFS_IRQ_MASK, 8'h00);
    check(irq, 0);
    bus(1, OFS_IRQ_MASK, 8'h07);
    bus(1, OFS_IRQ_STAT, 8'h07);
    check(irq, 0);
    boot(10, 4'h3);
    bus(0, OFS_INT_FLAGS, 8'h00);
    check(q, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
